// file: rtl/dlsc_pkg.sv
// Shared constants and types of the delayed lockstep checker
package dlsc_pkg;
	// ************************************************************
	// Widths and timing
	// ************************************************************
	localparam int DLSC_IN_W = 32;
	localparam int DLSC_CORE_W = 32;
	localparam int DLSC_CACHE_W = 32;
	localparam int DLSC_DELAY_CYC = 2;
	localparam int DLSC_SYS_CLK_MHZ = 50;
	localparam int DLSC_IRC_CLK_MHZ = 16;
	localparam int DLSC_FAULT_MAX_IRC_CYC = 10;
	// Longest allowed report latency in system cycles, rounded down
	localparam int DLSC_FAULT_MAX_SYS_CYC =
		(DLSC_FAULT_MAX_IRC_CYC * DLSC_SYS_CLK_MHZ) / DLSC_IRC_CLK_MHZ;
	// Cycles after reset release before the synchronised strap is caught
	localparam logic [1:0] DLSC_CFG_SETTLE = 2'h2;
	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic DLSC_RST_BIT = 1'b0;
	localparam logic [1:0] DLSC_RST_CNT = 2'h0;
	// ************************************************************
	// Mode state
	// ************************************************************
	typedef enum logic [2:0] {
		DLSC_ST_LOAD = 3'h1,
		DLSC_ST_ON = 3'h2,
		DLSC_ST_OFF = 3'h4
	} dlsc_mode_t;
endpackage

// file: rtl/dlsc_top.sv
// Delayed lockstep checker: input delay, output compare, fault reporting
// Contract
// - Checker core gets every master input delayed by exactly two cycles.
// - Checker outputs compared with aligned master outputs while lockstep active.
// - Any master/checker mismatch is reported to the fault collection unit.
// - Cache controller outputs are duplicated and compared as well.
// - Lockstep enable comes from one device configuration record bit.
// - Lockstep disabled turns off checker core and redundancy checker units.
// - Checker core never runs on its own, only shadows the master.
// - Lockstep state changes only through reset, never during operation.
// - Disabled lockstep raises a fault indication to the fault collection unit.
// - Detected fault reaches fault collection unit within ten oscillator cycles.
module dlsc_top
	import dlsc_pkg::*;
(
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	input wire logic LOCKSTEP_CFG_I,
	input wire logic [DLSC_IN_W-1:0] MST_IN_I,
	input wire logic [DLSC_CORE_W-1:0] MST_CORE_OUT_I,
	input wire logic [DLSC_CACHE_W-1:0] MST_CACHE_OUT_I,
	input wire logic [DLSC_CORE_W-1:0] CHK_CORE_OUT_I,
	input wire logic [DLSC_CACHE_W-1:0] CHK_CACHE_OUT_I,
	input wire logic FAULT_ACK_I,
	output logic [DLSC_IN_W-1:0] CHK_IN_O,
	output logic CHK_EN_O,
	output logic RCU_EN_O,
	output logic LOCKSTEP_ON_O,
	output logic FAULT_CORE_O,
	output logic FAULT_CACHE_O,
	output logic FAULT_LS_OFF_O
);
	// ************************************************************
	// Configuration strap capture
	// ************************************************************
	logic cfg_meta;
	logic cfg_sync;
	logic [1:0] settle_cnt;
	dlsc_mode_t mode;

	// Strap is treated as a pin, so only the second flop feeds logic
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			cfg_meta <= DLSC_RST_BIT;
		end else begin
			cfg_meta <= LOCKSTEP_CFG_I;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			cfg_sync <= DLSC_RST_BIT;
		end else begin
			cfg_sync <= cfg_meta;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			settle_cnt <= DLSC_RST_CNT;
		end else if (settle_cnt != DLSC_CFG_SETTLE) begin
			settle_cnt <= settle_cnt + 2'h1;
		end
	end

	// Mode is decided once after release and then frozen until the next reset
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			mode <= DLSC_ST_LOAD;
		end else begin
			case (mode)
				DLSC_ST_LOAD: begin
					if (settle_cnt == DLSC_CFG_SETTLE) begin
						mode <= cfg_sync ? DLSC_ST_ON : DLSC_ST_OFF;
					end
				end
				DLSC_ST_ON: mode <= DLSC_ST_ON;
				DLSC_ST_OFF: mode <= DLSC_ST_OFF;
				default: mode <= DLSC_ST_OFF;
			endcase
		end
	end

	logic ls_on;
	assign ls_on = (mode == DLSC_ST_ON);

	// ************************************************************
	// Input delay line towards the checker core
	// ************************************************************
	// Checker input is forced to zero when off, so it can never act on its own
	logic [DLSC_IN_W-1:0] in_d1;
	logic [DLSC_IN_W-1:0] next_chk_in;

	assign next_chk_in = ls_on ? in_d1 : '0;

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			in_d1 <= '0;
		end else begin
			in_d1 <= MST_IN_I;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			CHK_IN_O <= '0;
		end else begin
			CHK_IN_O <= next_chk_in;
		end
	end

	// Enables all follow the frozen mode, so none can toggle in operation
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			CHK_EN_O <= DLSC_RST_BIT;
		end else begin
			CHK_EN_O <= ls_on;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			RCU_EN_O <= DLSC_RST_BIT;
		end else begin
			RCU_EN_O <= ls_on;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			LOCKSTEP_ON_O <= DLSC_RST_BIT;
		end else begin
			LOCKSTEP_ON_O <= ls_on;
		end
	end

	// ************************************************************
	// Output alignment and comparison
	// ************************************************************
	// Master outputs wait two cycles so they meet the checker's matching ones
	logic [DLSC_CORE_W-1:0] mcore_d1;
	logic [DLSC_CORE_W-1:0] mcore_d2;
	logic [DLSC_CACHE_W-1:0] mcache_d1;
	logic [DLSC_CACHE_W-1:0] mcache_d2;
	logic [1:0] fill_cnt;
	logic cmp_valid;

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			mcore_d1 <= '0;
			mcore_d2 <= '0;
		end else begin
			mcore_d1 <= MST_CORE_OUT_I;
			mcore_d2 <= mcore_d1;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			mcache_d1 <= '0;
			mcache_d2 <= '0;
		end else begin
			mcache_d1 <= MST_CACHE_OUT_I;
			mcache_d2 <= mcache_d1;
		end
	end

	// The checker sees valid inputs only after the delay line has filled
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			fill_cnt <= DLSC_RST_CNT;
		end else if (!ls_on) begin
			fill_cnt <= DLSC_RST_CNT;
		end else if (fill_cnt != DLSC_DELAY_CYC[1:0]) begin
			fill_cnt <= fill_cnt + 2'h1;
		end
	end

	assign cmp_valid = ls_on && (fill_cnt == DLSC_DELAY_CYC[1:0]);

	logic core_miss;
	logic cache_miss;
	assign core_miss = cmp_valid && (CHK_CORE_OUT_I != mcore_d2);
	assign cache_miss = cmp_valid && (CHK_CACHE_OUT_I != mcache_d2);

	// ************************************************************
	// Fault reporting
	// ************************************************************
	// One register stage keeps the report far inside the allowed latency
	// A mismatch in the acknowledge cycle wins, so no event is lost
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			FAULT_CORE_O <= DLSC_RST_BIT;
		end else if (core_miss) begin
			FAULT_CORE_O <= 1'b1;
		end else if (FAULT_ACK_I) begin
			FAULT_CORE_O <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			FAULT_CACHE_O <= DLSC_RST_BIT;
		end else if (cache_miss) begin
			FAULT_CACHE_O <= 1'b1;
		end else if (FAULT_ACK_I) begin
			FAULT_CACHE_O <= 1'b0;
		end
	end

	// Lockstep off is a standing condition, so acknowledge cannot clear it
	always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			FAULT_LS_OFF_O <= DLSC_RST_BIT;
		end else begin
			FAULT_LS_OFF_O <= (mode == DLSC_ST_OFF);
		end
	end
endmodule

// file: dv/dlsc_fcu_model.sv
// Fault collection unit model: acknowledges raised faults after a set wait
module dlsc_fcu_model (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic ack_en_i,
	input wire logic [3:0] ack_wait_i,
	input wire logic fault_i,
	output logic ack_o
);
	logic [3:0] cnt;
	// One-cycle ack pulse; a stalled unit simply leaves the fault standing
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= 4'h0;
			ack_o <= 1'b0;
		end else begin
			ack_o <= fault_i && ack_en_i && cnt == ack_wait_i && !ack_o;
			cnt <= (fault_i && ack_en_i && !ack_o) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule

// file: dv/dlsc_top_chk.sv
// Port assertions for the delayed lockstep checker
module dlsc_top_chk
	import dlsc_pkg::*;
(
	input wire logic SYS_CLK_I,
	input wire logic RSTN_I,
	input wire logic LOCKSTEP_CFG_I,
	input wire logic [DLSC_IN_W-1:0] MST_IN_I,
	input wire logic [DLSC_CORE_W-1:0] MST_CORE_OUT_I,
	input wire logic [DLSC_CACHE_W-1:0] MST_CACHE_OUT_I,
	input wire logic [DLSC_CORE_W-1:0] CHK_CORE_OUT_I,
	input wire logic [DLSC_CACHE_W-1:0] CHK_CACHE_OUT_I,
	input wire logic FAULT_ACK_I,
	input wire logic [DLSC_IN_W-1:0] CHK_IN_O,
	input wire logic CHK_EN_O,
	input wire logic RCU_EN_O,
	input wire logic LOCKSTEP_ON_O,
	input wire logic FAULT_CORE_O,
	input wire logic FAULT_CACHE_O,
	input wire logic FAULT_LS_OFF_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RSTN_I);
	chk_in_delay: assert property (LOCKSTEP_ON_O |-> CHK_IN_O == $past(MST_IN_I, 2))
		else $error("late input wrong");
	chk_units_off: assert property (!LOCKSTEP_ON_O |-> CHK_IN_O == 32'h0 && !CHK_EN_O && !RCU_EN_O)
		else $error("checker not off");
	chk_mode_held: assert property ($past(LOCKSTEP_ON_O) |-> LOCKSTEP_ON_O && CHK_EN_O && RCU_EN_O)
		else $error("mode changed");
	chk_off_fault: assert property ($past(FAULT_LS_OFF_O) |-> FAULT_LS_OFF_O && !LOCKSTEP_ON_O)
		else $error("off fault dropped");
	chk_core_flag: assert property (LOCKSTEP_ON_O && $past(LOCKSTEP_ON_O) &&
		CHK_CORE_OUT_I != $past(MST_CORE_OUT_I, 2) |=> FAULT_CORE_O) else $error("core miss");
	chk_cache_flag: assert property (LOCKSTEP_ON_O && $past(LOCKSTEP_ON_O) &&
		CHK_CACHE_OUT_I != $past(MST_CACHE_OUT_I, 2) |=> FAULT_CACHE_O) else $error("cache miss");
	chk_fault_hold: assert property (FAULT_CORE_O && !FAULT_ACK_I |=> FAULT_CORE_O)
		else $error("fault dropped");
	chk_ack_clear: assert property (FAULT_ACK_I && CHK_CORE_OUT_I == $past(MST_CORE_OUT_I, 2) &&
		CHK_CACHE_OUT_I == $past(MST_CACHE_OUT_I, 2) |=> !FAULT_CORE_O) else $error("ack lost");
endmodule
bind dlsc_top dlsc_top_chk chk(.*);

// file: dv/test_dlsc_top.sv
// Self-checking bench for the delayed lockstep checker
module test_dlsc_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic SYS_CLK_I, RSTN_I, LOCKSTEP_CFG_I, FAULT_ACK_I, CHK_EN_O, RCU_EN_O, LOCKSTEP_ON_O;
	logic FAULT_CORE_O, FAULT_CACHE_O, FAULT_LS_OFF_O, ack_en;
	logic [31:0] MST_IN_I, MST_CORE_OUT_I, MST_CACHE_OUT_I, CHK_CORE_OUT_I, CHK_CACHE_OUT_I, CHK_IN_O;
	logic [3:0] wt;
	int err_count, checked, cyc;
	dlsc_top DUT(.*);
	dlsc_fcu_model fcu(.clk_i(SYS_CLK_I), .rstn_i(RSTN_I), .ack_en_i(ack_en), .ack_wait_i(wt),
		.fault_i(FAULT_CORE_O | FAULT_CACHE_O | FAULT_LS_OFF_O), .ack_o(FAULT_ACK_I));
	task check(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task close_out;
		if (err_count == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Zero for the first two steps so the checker side starts aligned after boot
	function logic [31:0] dly(input int i);
		return i < 2 ? 32'h0 : 32'h5a3c_0000 ^ (i - 2) * 32'h0101_0101;
	endfunction
	task boot(input logic en);
		RSTN_I = 1'b0;
		LOCKSTEP_CFG_I = en;
		{MST_IN_I, MST_CORE_OUT_I, CHK_CORE_OUT_I, MST_CACHE_OUT_I, CHK_CACHE_OUT_I} = '0;
		repeat (6) @(posedge SYS_CLK_I);
		#2 RSTN_I = 1'b1;
		repeat (4) @(posedge SYS_CLK_I);
		#2 check("mode", {LOCKSTEP_ON_O, CHK_EN_O, RCU_EN_O, FAULT_LS_OFF_O}, {en, en, en, !en});
	endtask
	task run(input logic en, input int bad);
		wt = en ? 4'h4 : 4'h0;
		for (int i = 0; i < bad + 25; i++) begin
			@(posedge SYS_CLK_I);
			#2 check("late input", CHK_IN_O, en ? dly(i) : 32'h0);
			if (i == bad + 1 || i == bad + 4)
				check("core fault", FAULT_CORE_O, en);
			if (i == bad + 15)
				check("cache fault", FAULT_CACHE_O, en);
			ack_en = i > bad + 4;
			LOCKSTEP_CFG_I = i == 3 ? !en : en;
			MST_IN_I = dly(i + 2);
			MST_CORE_OUT_I = dly(i + 2);
			MST_CACHE_OUT_I = dly(i + 2);
			CHK_CORE_OUT_I = dly(i) ^ (i == bad);
			CHK_CACHE_OUT_I = dly(i) ^ (i == bad + 14);
		end
		check("faults", {FAULT_CORE_O, FAULT_CACHE_O, FAULT_LS_OFF_O, LOCKSTEP_ON_O}, {2'h0, !en, en});
	endtask
	initial begin
		SYS_CLK_I = 1'b0;
		forever #10 SYS_CLK_I = ~SYS_CLK_I;
	end
	always @(posedge SYS_CLK_I) begin
		cyc++;
		if (cyc == 400) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		ack_en = 1'b0;
		wt = 4'h0;
		boot(1'b1);
		run(1'b1, 8);
		boot(1'b0);
		run(1'b0, 8);
		close_out();
	end
endmodule
